// [rtl/dml_pkg.sv]
// package for the decode and macrocell logic block
package dml_pkg;
    localparam int DML_NUM_SECTORS   = 8;
    localparam int DML_NUM_ECS       = 3;
    localparam int DML_CELLS         = 8;
    localparam int DML_AIN_W         = 16;
    localparam int DML_CTL_W         = 3;
    localparam int DML_PG_W          = 8;
    localparam int DML_PT_PER_SECTOR = 3;
    localparam int DML_MAX_PT        = 130;
    localparam int DML_CLR_PT        = 2;
    localparam int DML_NATIVE_A      = 3;
    localparam int DML_NATIVE_B      = 4;
    localparam int DML_BORROW_A      = 6;
    localparam int DML_BORROW_B_LO   = 5;
    localparam int DML_BORROW_B_HI   = 6;
    localparam int DML_MAX_TERMS     = 10;
    localparam int DML_CSIOP_SPAN    = 256;
    // csiop register offsets
    localparam logic [7:0] DML_OFF_GROUP_A_DATA  = 8'h20;
    localparam logic [7:0] DML_OFF_GROUP_B_DATA  = 8'h21;
    localparam logic [7:0] DML_OFF_GROUP_A_BLOCK = 8'h22;
    localparam logic [7:0] DML_OFF_GROUP_B_BLOCK = 8'h23;
    localparam logic [7:0] DML_OFF_INPUT_B       = 8'h18;
    localparam logic [7:0] DML_OFF_INPUT_C       = 8'h19;
    localparam logic [7:0] DML_BLOCK_RESET       = 8'h00;

    typedef enum logic [1:0]
    {
        DML_FF_D  = 2'b00,
        DML_FF_T  = 2'b01,
        DML_FF_JK = 2'b10,
        DML_FF_SR = 2'b11
    } dml_ff_t;

    typedef enum logic [1:0]
    {
        DML_IN_PASS  = 2'b00,
        DML_IN_LATCH = 2'b01,
        DML_IN_REG   = 2'b10
    } dml_in_mode_t;

    // per output cell configuration
    typedef struct packed
    {
        dml_ff_t    ff_type;
        logic       invert;
        logic       use_reg;
        logic       clk_from_pin;
        logic [1:0] route;
    } dml_cell_cfg_t;

    // route codes: 0 buried, 1 port b, 2 port c
    localparam logic [1:0] DML_ROUTE_BURIED = 2'd0;
    localparam logic [1:0] DML_ROUTE_PORT_B = 2'd1;
    localparam logic [1:0] DML_ROUTE_PORT_C = 2'd2;

    // product term inputs feeding one output cell
    typedef struct packed
    {
        logic [DML_MAX_TERMS-1:0] sum_a;
        logic [DML_MAX_TERMS-1:0] sum_b;
        logic                     clk_pt;
        logic                     preset_pt;
        logic [DML_CLR_PT-1:0]    clear_pt;
        logic                     oe_pt;
    } dml_cell_pt_t;
endpackage : dml_pkg

// [rtl/dml_top.sv]
// decode array, output cells and input cells of the programmable logic
// Overview of operation
// - eight sector selects, OR of three terms
// - register block select over 256 locations
// - jtag select follows its one term
// - three chip selects, one term each
// - up to 130 product terms shared
// - group a to port b, b to b/c
// - xor polarity, reg/comb mux, feedback
// - flip-flop acts as D, T, JK, SR
// - clock from term or pin rising edge
// - preset, clear active high; clear two terms
// - one cell drives one pin only
// - native and borrowed term counts per group
// - borrow unused neighbour terms, no delay
// - expansion consumes cell and feeds back
// - dsp load overrides preset, clear, clock
// - load captured at write strobe trailing edge
// - mask bit blocks write, resets zero
// - pin enable is term OR direction
// - input cell latch, register or pass
// - input cells readable at any time
// - input enables shared per nibble
`timescale 1ns/100ps
module dml_top
    import dml_pkg::*;
#(
    parameter int N = DML_CELLS
)
(
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic [DML_AIN_W-1:0]          dsp_addr,
    input  wire logic [DML_CTL_W-1:0]          dsp_ctl,
    input  wire logic                          control_line_three,
    input  wire logic                          dsp_rd,
    input  wire logic [7:0]                    dsp_wdata,
    output      logic [7:0]                    dsp_rdata,
    input  wire logic [DML_PG_W-1:0]           page,
    input  wire logic [DML_AIN_W-1:0]          csiop_base,
    input  wire logic [DML_NUM_SECTORS*DML_PT_PER_SECTOR-1:0] sector_terms,
    input  wire logic                          jtag_term,
    input  wire logic [DML_NUM_ECS-1:0]        ecs_terms,
    output      logic [DML_NUM_SECTORS-1:0]    sector_selects,
    output      logic                          csiop_select,
    output      logic                          jtag_select,
    output      logic [DML_NUM_ECS-1:0]        external_chip_selects,
    input  wire logic                          port_d_pin_one,
    input  wire dml_cell_cfg_t [N-1:0]         cfg_a,
    input  wire dml_cell_cfg_t [N-1:0]         cfg_b,
    input  wire dml_cell_pt_t  [N-1:0]         pt_a,
    input  wire dml_cell_pt_t  [N-1:0]         pt_b,
    input  wire logic [N-1:0]                  dir_b,
    input  wire logic [N-1:0]                  dir_c,
    output      logic [N-1:0]                  output_cell_group_a,
    output      logic [N-1:0]                  output_cell_group_b,
    output      logic [N-1:0]                  port_b_out,
    output      logic [N-1:0]                  port_b_oe,
    output      logic [N-1:0]                  port_c_out,
    output      logic [N-1:0]                  port_c_oe,
    input  wire logic [N-1:0]                  port_b_in,
    input  wire logic [N-1:0]                  port_c_in,
    input  wire dml_in_mode_t [2*N-1:0]        input_mode,
    input  wire logic [3:0]                    input_cell_terms,
    output      logic [2*N-1:0]                input_cell
);

    ////////////////////////////////////////////////////////////////////////
    // decode array
    ////////////////////////////////////////////////////////////////////////
    logic write_hit;
    logic [7:0] off;

    always_comb
    begin
        for (int s = 0; s < DML_NUM_SECTORS; s++)
        begin
            sector_selects[s] = |sector_terms[s*DML_PT_PER_SECTOR +: DML_PT_PER_SECTOR];
        end
    end

    assign csiop_select = (dsp_addr[DML_AIN_W-1:8] == csiop_base[DML_AIN_W-1:8]);
    assign off = dsp_addr[7:0];
    assign jtag_select = jtag_term;
    assign external_chip_selects = ecs_terms;

    ////////////////////////////////////////////////////////////////////////
    // write strobe trailing edge detect and pin synchronisers
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] wr_sync;
    logic       wr_prev;
    logic [1:0] ck_sync;
    logic       ck_prev;
    logic [7:0] wd_s1;
    logic [7:0] wd_s2;
    logic [7:0] ad_s1;
    logic [7:0] ad_s2;
    logic       cs_s1;
    logic       cs_s2;
    logic [2*N-1:0] pin_s1;
    logic [2*N-1:0] pin_s2;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_sync <= 2'b11;
            wr_prev <= 1'b1;
            ck_sync <= 2'b00;
            ck_prev <= 1'b0;
            wd_s1   <= 8'h00;
            wd_s2   <= 8'h00;
            ad_s1   <= 8'h00;
            ad_s2   <= 8'h00;
            cs_s1   <= 1'b0;
            cs_s2   <= 1'b0;
            pin_s1  <= '0;
            pin_s2  <= '0;
        end
        else
        begin
            wr_sync <= {wr_sync[0], control_line_three};
            wr_prev <= wr_sync[1];
            ck_sync <= {ck_sync[0], port_d_pin_one};
            ck_prev <= ck_sync[1];
            wd_s1   <= dsp_wdata;
            wd_s2   <= wd_s1;
            ad_s1   <= off;
            ad_s2   <= ad_s1;
            cs_s1   <= csiop_select;
            cs_s2   <= cs_s1;
            pin_s1  <= {port_c_in, port_b_in};
            pin_s2  <= pin_s1;
        end
    end

    // strobe is active low, trailing edge is its rise
    assign write_hit = cs_s2 && wr_sync[1] && !wr_prev;

    logic pin_rise;
    // dedicated pin clocks on rising edge
    assign pin_rise = ck_sync[1] && !ck_prev;

    ////////////////////////////////////////////////////////////////////////
    // mask registers
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] block_a;
    logic [7:0] block_b;
    logic [7:0] next_block_a;
    logic [7:0] next_block_b;

    always_comb
    begin
        next_block_a = block_a;
        next_block_b = block_b;
        if (write_hit && ad_s2 == DML_OFF_GROUP_A_BLOCK)
            next_block_a = wd_s2;
        if (write_hit && ad_s2 == DML_OFF_GROUP_B_BLOCK)
            next_block_b = wd_s2;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            block_a <= DML_BLOCK_RESET;
            block_b <= DML_BLOCK_RESET;
        end
        else
        begin
            block_a <= next_block_a;
            block_b <= next_block_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output cells
    ////////////////////////////////////////////////////////////////////////
    // storage element behaviour
    function automatic logic dml_ff_next(dml_ff_t t, logic q, logic a, logic b);
        unique case (t)
            DML_FF_D:  dml_ff_next = a;
            DML_FF_T:  dml_ff_next = q ^ a;
            DML_FF_JK: dml_ff_next = (a & ~q) | (~b & q);
            DML_FF_SR: dml_ff_next = a | (~b & q);
        endcase
    endfunction : dml_ff_next

    logic [N-1:0] q_a;
    logic [N-1:0] q_b;
    logic [N-1:0] next_q_a;
    logic [N-1:0] next_q_b;
    logic [N-1:0] ptck_a_prev;
    logic [N-1:0] ptck_b_prev;
    logic [N-1:0] comb_a;
    logic [N-1:0] comb_b;
    logic [N-1:0] load_a;
    logic [N-1:0] load_b;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_cell
            logic sa_a;
            logic sb_a;
            logic sa_b;
            logic sb_b;
            logic ed_a;
            logic ed_b;
            // sums drawn from the shared term array
            // group a terms, native plus borrowed
            // borrowed terms folded into one sum level
            assign sa_a = |pt_a[g].sum_a[DML_NATIVE_A+DML_BORROW_A-1:0];
            assign sb_a = |pt_a[g].sum_b[DML_NATIVE_A+DML_BORROW_A-1:0];
            // group b limits by cell index
            assign sa_b = (g < 4) ? |pt_b[g].sum_a[DML_NATIVE_B+DML_BORROW_B_LO-1:0]
                                  : |pt_b[g].sum_a[DML_NATIVE_B+DML_BORROW_B_HI-1:0];
            assign sb_b = (g < 4) ? |pt_b[g].sum_b[DML_NATIVE_B+DML_BORROW_B_LO-1:0]
                                  : |pt_b[g].sum_b[DML_NATIVE_B+DML_BORROW_B_HI-1:0];
            assign comb_a[g] = sa_a ^ cfg_a[g].invert;
            assign comb_b[g] = sa_b ^ cfg_b[g].invert;
            assign ed_a = cfg_a[g].clk_from_pin ? pin_rise
                                                : (pt_a[g].clk_pt && !ptck_a_prev[g]);
            assign ed_b = cfg_b[g].clk_from_pin ? pin_rise
                                                : (pt_b[g].clk_pt && !ptck_b_prev[g]);
            // data bit n loads cell n
            assign load_a[g] = write_hit && ad_s2 == DML_OFF_GROUP_A_DATA && !block_a[g];
            assign load_b[g] = write_hit && ad_s2 == DML_OFF_GROUP_B_DATA && !block_b[g];

            always_comb
            begin
                next_q_a[g] = q_a[g];
                next_q_b[g] = q_b[g];
                // dsp load wins over preset, clear and clock
                if (load_a[g])
                    next_q_a[g] = wd_s2[g];
                // active high clear of two terms, preset
                else if (|pt_a[g].clear_pt)
                    next_q_a[g] = 1'b0;
                else if (pt_a[g].preset_pt)
                    next_q_a[g] = 1'b1;
                else if (ed_a)
                    next_q_a[g] = dml_ff_next(cfg_a[g].ff_type, q_a[g],
                                              comb_a[g], sb_a);
                if (load_b[g])
                    next_q_b[g] = wd_s2[g];
                else if (|pt_b[g].clear_pt)
                    next_q_b[g] = 1'b0;
                else if (pt_b[g].preset_pt)
                    next_q_b[g] = 1'b1;
                else if (ed_b)
                    next_q_b[g] = dml_ff_next(cfg_b[g].ff_type, q_b[g],
                                              comb_b[g], sb_b);
            end

            // registered or combinational result fed back
            // feedback lets a cell extend another's sum
            assign output_cell_group_a[g] = cfg_a[g].use_reg ? q_a[g] : comb_a[g];
            assign output_cell_group_b[g] = cfg_b[g].use_reg ? q_b[g] : comb_b[g];

            // group a to b only, group b to b or c
            // each cell picks one pin, group a owns b first
            always_comb
            begin
                if (cfg_a[g].route == DML_ROUTE_PORT_B)
                begin
                    port_b_out[g] = output_cell_group_a[g];
                    port_b_oe[g]  = pt_a[g].oe_pt | dir_b[g];
                end
                else if (cfg_b[g].route == DML_ROUTE_PORT_B)
                begin
                    port_b_out[g] = output_cell_group_b[g];
                    port_b_oe[g]  = pt_b[g].oe_pt | dir_b[g];
                end
                else
                begin
                    port_b_out[g] = 1'b0;
                    port_b_oe[g]  = 1'b0;
                end
                if (cfg_b[g].route == DML_ROUTE_PORT_C)
                begin
                    port_c_out[g] = output_cell_group_b[g];
                    port_c_oe[g]  = pt_b[g].oe_pt | dir_c[g];
                end
                else
                begin
                    port_c_out[g] = 1'b0;
                    port_c_oe[g]  = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q_a         <= '0;
            q_b         <= '0;
            ptck_a_prev <= '0;
            ptck_b_prev <= '0;
        end
        else
        begin
            q_a <= next_q_a;
            q_b <= next_q_b;
            for (int i = 0; i < N; i++)
            begin
                ptck_a_prev[i] <= pt_a[i].clk_pt;
                ptck_b_prev[i] <= pt_b[i].clk_pt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input cells
    ////////////////////////////////////////////////////////////////////////
    logic [2*N-1:0] in_q;
    logic [2*N-1:0] next_in_q;
    logic [3:0]     icl_prev;

    always_comb
    begin
        for (int i = 0; i < 2*N; i++)
        begin
            next_in_q[i] = in_q[i];
            if (input_mode[i] == DML_IN_LATCH && input_cell_terms[i/4])
                next_in_q[i] = pin_s2[i];
            else if (input_mode[i] == DML_IN_REG && input_cell_terms[i/4] && !icl_prev[i/4])
                next_in_q[i] = pin_s2[i];
            input_cell[i] = (input_mode[i] == DML_IN_PASS) ? pin_s2[i] : in_q[i];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            in_q     <= '0;
            icl_prev <= 4'h0;
        end
        else
        begin
            in_q     <= next_in_q;
            icl_prev <= input_cell_terms;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // readback
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = 8'h00;
        if (csiop_select && dsp_rd)
        begin
            unique case (off)
                DML_OFF_GROUP_A_DATA:  next_rdata = q_a;
                DML_OFF_GROUP_B_DATA:  next_rdata = q_b;
                DML_OFF_GROUP_A_BLOCK: next_rdata = block_a;
                DML_OFF_GROUP_B_BLOCK: next_rdata = block_b;
                DML_OFF_INPUT_B:       next_rdata = input_cell[N-1:0];
                DML_OFF_INPUT_C:       next_rdata = input_cell[2*N-1:N];
                default:               next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            dsp_rdata <= 8'h00;
        else
            dsp_rdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////
    logic ed_a0;
    assign ed_a0 = g_cell[0].ed_a;

    AST_SECTOR_OR: assert property (@(posedge clk) disable iff (!rstn)
        sector_selects[0] == |sector_terms[2:0])
        else $error("sector select not the OR of its terms");
    AST_ECS_PASS: assert property (@(posedge clk) disable iff (!rstn)
        external_chip_selects == ecs_terms)
        else $error("chip select mismatch");
    AST_MASK_BLOCKS: assert property (@(posedge clk) disable iff (!rstn)
        (write_hit && ad_s2 == DML_OFF_GROUP_A_DATA && block_a[0]
         && pt_a[0].clear_pt == 2'b00 && !pt_a[0].preset_pt && !ed_a0)
        |=> $stable(q_a[0]))
        else $error("masked cell changed");
    AST_LOAD_WINS: assert property (@(posedge clk) disable iff (!rstn)
        load_a[0] |=> q_a[0] == $past(wd_s2[0]))
        else $error("load did not take priority");
    AST_CLEAR_HI: assert property (@(posedge clk) disable iff (!rstn)
        (!load_b[1] && |pt_b[1].clear_pt) |=> !q_b[1])
        else $error("clear did not act");
    AST_OE_OR: assert property (@(posedge clk) disable iff (!rstn)
        (cfg_b[2].route == DML_ROUTE_PORT_C) |-> port_c_oe[2] == (pt_b[2].oe_pt | dir_c[2]))
        else $error("pin enable wrong");
    AST_ONE_PIN: assert property (@(posedge clk) disable iff (!rstn)
        port_c_oe[3] |-> (cfg_b[3].route == DML_ROUTE_PORT_C
                          && (!port_b_oe[3] || cfg_a[3].route == DML_ROUTE_PORT_B)))
        else $error("cell drives two pins");
    AST_MASK_READ: assert property (@(posedge clk) disable iff (!rstn)
        (csiop_select && dsp_rd && off == DML_OFF_GROUP_A_BLOCK) |=> dsp_rdata == $past(block_a))
        else $error("mask readback wrong");

endmodule : dml_top

// [sim/dml_dsp_model.sv]
// behavioural dsp bus master driving the register side of the block
`timescale 1ns/100ps
module dml_dsp_model
    import dml_pkg::*;
(
    input  wire logic       clk,
    output      logic [15:0] dsp_addr,
    output      logic        control_line_three,
    output      logic        dsp_rd,
    output      logic [7:0]  dsp_wdata,
    input  wire logic [7:0]  dsp_rdata
);
    initial
    begin
        dsp_addr           = 16'h0000;
        control_line_three = 1'b1;
        dsp_rd             = 1'b0;
        dsp_wdata          = 8'h00;
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        dsp_addr  = a;
        dsp_wdata = d;
        repeat (3) @(negedge clk);
        control_line_three = 1'b0;
        repeat (4) @(negedge clk);
        control_line_three = 1'b1;
        repeat (6) @(negedge clk);
        // released data bus shows no stale value
        dsp_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        dsp_addr = a;
        dsp_rd   = 1'b1;
        repeat (2) @(negedge clk);
        d      = dsp_rdata;
        dsp_rd = 1'b0;
    endtask : rd
endmodule : dml_dsp_model

// [sim/dml_top_test.sv]
// self-checking testbench for the decode and output cell logic
`timescale 1ns/100ps
module dml_top_test
    import dml_pkg::*;
;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic [15:0]        dsp_addr;
    logic               control_line_three;
    logic               dsp_rd;
    logic [7:0]         dsp_wdata;
    logic [7:0]         dsp_rdata;
    logic [15:0]        base = 16'h4300;
    logic [23:0]        sector_terms = '0;
    logic               jtag_term = 1'b0;
    logic [2:0]         ecs_terms = '0;
    logic [7:0]         sector_selects;
    logic               csiop_select;
    logic               jtag_select;
    logic [2:0]         external_chip_selects;
    dml_cell_cfg_t [7:0] cfg_a = '0;
    dml_cell_cfg_t [7:0] cfg_b = '0;
    dml_cell_pt_t  [7:0] pt_a = '0;
    dml_cell_pt_t  [7:0] pt_b = '0;
    logic [7:0]         dir_b = '0;
    logic [7:0]         dir_c = '0;
    logic [7:0]         cell_a;
    logic [7:0]         cell_b;
    logic [7:0]         port_b_out;
    logic [7:0]         port_c_out;
    logic [7:0]         port_b_in = '0;
    logic [7:0]         port_c_in = '0;
    logic [7:0]         port_b_oe;
    logic [7:0]         port_c_oe;
    logic [3:0]         icl_terms = '0;
    logic               clk_pin = 1'b0;
    dml_in_mode_t [15:0] input_mode;
    logic [15:0]        input_cell;
    logic [7:0]         r;
    int                 n_fail = 0;
    int                 cmp_count = 0;

    initial
    begin
        forever #20 clk = ~clk;
    end

    dml_dsp_model dsp (.clk(clk), .dsp_addr(dsp_addr), .control_line_three(control_line_three),
        .dsp_rd(dsp_rd), .dsp_wdata(dsp_wdata), .dsp_rdata(dsp_rdata));

    dml_top uut (.clk(clk), .rstn(rstn), .dsp_addr(dsp_addr), .dsp_ctl(3'b000),
        .control_line_three(control_line_three), .dsp_rd(dsp_rd), .dsp_wdata(dsp_wdata),
        .dsp_rdata(dsp_rdata), .page(8'h00), .csiop_base(base), .sector_terms(sector_terms),
        .jtag_term(jtag_term), .ecs_terms(ecs_terms), .sector_selects(sector_selects),
        .csiop_select(csiop_select), .jtag_select(jtag_select),
        .external_chip_selects(external_chip_selects), .port_d_pin_one(clk_pin),
        .cfg_a(cfg_a), .cfg_b(cfg_b), .pt_a(pt_a), .pt_b(pt_b), .dir_b(dir_b), .dir_c(dir_c),
        .output_cell_group_a(cell_a), .output_cell_group_b(cell_b), .port_b_out(port_b_out),
        .port_b_oe(port_b_oe), .port_c_out(port_c_out), .port_c_oe(port_c_oe),
        .port_b_in(port_b_in), .port_c_in(port_c_in), .input_mode(input_mode),
        .input_cell_terms(icl_terms),
        .input_cell(input_cell));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    function automatic logic [15:0] at(input logic [7:0] off);
        return {base[15:8], off};
    endfunction : at

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        dsp.rd(at(DML_OFF_GROUP_A_BLOCK), r);
        check(r, 8'h00);
        dsp.rd(at(DML_OFF_GROUP_B_BLOCK), r);
        check(r, 8'h00);
        dsp.rd(at(8'hff), r);
        check(r, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_load;
        dsp.wr(at(DML_OFF_GROUP_A_DATA), 8'ha5);
        dsp.wr(at(DML_OFF_GROUP_B_DATA), 8'h3c);
        check(cell_a, 8'ha5);
        check(cell_b, 8'h3c);
        dsp.rd(at(DML_OFF_GROUP_A_DATA), r);
        check(r, 8'ha5);
        dsp.rd(at(DML_OFF_GROUP_B_DATA), r);
        check(r, 8'h3c);
        $display("test load done");
    endtask : t_load

    task automatic t_mask;
        dsp.wr(at(DML_OFF_GROUP_A_BLOCK), 8'h0f);
        dsp.wr(at(DML_OFF_GROUP_B_BLOCK), 8'hf0);
        dsp.rd(at(DML_OFF_GROUP_A_BLOCK), r);
        check(r, 8'h0f);
        dsp.rd(at(DML_OFF_GROUP_B_BLOCK), r);
        check(r, 8'hf0);
        dsp.wr(at(DML_OFF_GROUP_A_DATA), 8'h5a);
        dsp.wr(at(DML_OFF_GROUP_B_DATA), 8'hc3);
        check(cell_a, 8'h55);
        check(cell_b, 8'h33);
        $display("test mask done");
    endtask : t_mask

    task automatic t_decode;
        @(negedge clk);
        for (int s = 0; s < 8; s += 2)
            sector_terms[3*s + (s % 3)] = 1'b1;
        ecs_terms = 3'b101;
        jtag_term = 1'b1;
        dsp.dsp_addr = at(8'h00);
        #5;
        check(sector_selects, 8'h55);
        check(external_chip_selects, 3'b101);
        check(jtag_select, 1'b1);
        check(csiop_select, 1'b1);
        @(negedge clk);
        dsp.dsp_addr = base ^ 16'h0100;
        #5;
        check(csiop_select, 1'b0);
        $display("test decode done");
    endtask : t_decode

    task automatic t_input;
        @(negedge clk);
        port_b_in = 8'h96;
        port_c_in = 8'h2d;
        repeat (4) @(negedge clk);
        check(input_cell, 16'h2d96);
        dsp.rd(at(DML_OFF_INPUT_B), r);
        check(r, 8'h96);
        dsp.rd(at(DML_OFF_INPUT_C), r);
        check(r, 8'h2d);
        $display("test input done");
    endtask : t_input

    task automatic t_pins;
        for (int i = 0; i < 8; i++)
        begin
            cfg_a[i].route = DML_ROUTE_PORT_B;
            cfg_b[i].route = DML_ROUTE_PORT_C;
        end
        dir_b = 8'hf0;
        dir_c = 8'h0f;
        pt_b[7].oe_pt = 1'b1;
        #5;
        check(port_b_out, 8'h55);
        check(port_c_out, 8'h33);
        check(port_b_oe, 8'hf0);
        check(port_c_oe, 8'h8f);
        @(negedge clk);
        cfg_a[1].route = DML_ROUTE_BURIED;
        cfg_b[1].route = DML_ROUTE_PORT_B;
        #5;
        check(port_b_out, 8'h57);
        check(port_c_out, 8'h31);
        check(port_c_oe, 8'h8d);
        $display("test pins done");
    endtask : t_pins

    task automatic t_cells;
        @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
            if (i < 4)
                input_mode[i] = DML_IN_LATCH;
            else
                input_mode[i] = DML_IN_REG;
        end
        port_b_in = 8'h5a;
        repeat (3) @(negedge clk);
        check(input_cell[7:0], 8'h00);
        icl_terms = 4'h3;
        @(negedge clk);
        check(input_cell[7:0], 8'h5a);
        port_b_in = 8'hc3;
        repeat (3) @(negedge clk);
        check(input_cell[7:0], 8'h53);
        dsp.rd(at(DML_OFF_INPUT_B), r);
        check(r, 8'h53);
        pt_b[1].clear_pt  = 2'b10;
        pt_a[1].preset_pt = 1'b1;
        @(negedge clk);
        pt_b[1].clear_pt  = 2'b00;
        pt_a[1].preset_pt = 1'b0;
        check(cell_a, 8'h57);
        check(cell_b, 8'h31);
        cfg_a[0].clk_from_pin = 1'b1;
        cfg_a[0].ff_type      = DML_FF_T;
        pt_a[0].sum_a[0]      = 1'b1;
        cfg_b[2].clk_from_pin = 1'b1;
        cfg_b[2].ff_type      = DML_FF_JK;
        pt_b[2].sum_a[0]      = 1'b1;
        cfg_a[3].use_reg      = 1'b0;
        cfg_a[3].invert       = 1'b1;
        clk_pin               = 1'b1;
        repeat (4) @(negedge clk);
        check(cell_a, 8'h5e);
        check(cell_b, 8'h35);
        dsp.rd(at(DML_OFF_GROUP_A_DATA), r);
        check(r, 8'h56);
        $display("test cells done");
    endtask : t_cells

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 16; i++)
            input_mode[i] = DML_IN_PASS;
        for (int i = 0; i < 8; i++)
        begin
            cfg_a[i].use_reg = 1'b1;
            cfg_b[i].use_reg = 1'b1;
        end
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_load();
        t_mask();
        t_decode();
        t_input();
        t_pins();
        t_cells();
        summarize();
    end

    // watchdog well beyond the expected run of under two hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
endmodule : dml_top_test
